// *** rtl/amp_fault_irq_params.svh ***
// Register offsets, field positions and reset values of the amplifier fault interrupt block.
`ifndef AMP_FAULT_IRQ_PARAMS_SVH
`define AMP_FAULT_IRQ_PARAMS_SVH

// Register addresses on the device control port.
`define AFI_ADDR_INT_ENABLE_MASK  8'h05
`define AFI_ADDR_INT_STATUS_CLEAR 8'h06
`define AFI_ADDR_PIN_IO_CONFIG    8'h0A

// Reset values of the writable registers.
`define AFI_RST_INT_ENABLE_MASK   16'h0000
`define AFI_RST_PIN_IO_CONFIG     16'h0000

// Field positions inside the enable and mask register.
`define AFI_MASK_LSB              0
`define AFI_DISABLE_LSB           8

// Field positions inside the pin configuration register.
`define AFI_IO_OUT_ENABLE_BIT     11
`define AFI_IO_ACTIVE_HIGH_BIT    15

// Status bit positions of the two conditions.
`define AFI_COND_POWER            0
`define AFI_COND_BOOST_OV         1
`define AFI_NUM_COND              2

`endif

// *** rtl/amp_fault_irq_pkg.sv ***
// Types shared by the amplifier fault interrupt block.
`default_nettype none
package amp_fault_irq_pkg;

   typedef logic [15:0] reg_word_t;

   // Which register an access on the control port addresses.
   typedef enum logic [1:0] {
      SEL_NONE,
      SEL_ENABLE_MASK,
      SEL_STATUS_CLEAR,
      SEL_IO_CONFIG
   } reg_sel_t;

endpackage : amp_fault_irq_pkg
`default_nettype wire

// *** rtl/cond_sync_edge.sv ***
// Two-stage synchroniser with edge detection for asynchronous condition pins.
`timescale 1ns/1ns
`default_nettype none

module cond_sync_edge #(
   parameter int WIDTH = 3
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncLevel,
   output logic      [WIDTH-1:0] syncRise,
   output logic      [WIDTH-1:0] syncFall
);

   if (WIDTH < 1) begin : g_bad_width
      $error("cond_sync_edge needs WIDTH of at least one.");
   end

   // Per bit: the first flop feeds only the second, the third flop remembers the last level.
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_r;
      logic meta_nxt;
      logic level_r;
      logic level_nxt;
      logic prev_r;
      logic prev_nxt;

      // Next values of the three stages.
      always_comb begin
         meta_nxt  = asyncIn[i];
         level_nxt = meta_r;
         prev_nxt  = level_r;
      end

      // Registers clear on reset so no edge is seen right after release.
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            meta_r  <= 1'h0;
            level_r <= 1'h0;
            prev_r  <= 1'h0;
         end else begin
            meta_r  <= meta_nxt;
            level_r <= level_nxt;
            prev_r  <= prev_nxt;
         end
      end

      // Edges compare the stable stage with its delayed copy only.
      assign syncLevel[i] = level_r;
      assign syncRise[i]  = level_r & ~prev_r;
      assign syncFall[i]  = ~level_r & prev_r;
   end

endmodule : cond_sync_edge
`default_nettype wire

// *** rtl/amp_fault_irq_controller.sv ***
// Interrupt request logic of the amplifier: status latching, disable and mask, IRQ pin drive.
`timescale 1ns/1ns
`default_nettype none
`include "amp_fault_irq_params.svh"

// Functional notes
// - The IRQ pin goes active whenever an enabled and unmasked status bit is set.
// - The pin configuration field holds output enable and polarity, bit 15 choosing active high.
// - Writing one to a status bit clears it and writing zero leaves it alone.
// - A set disable bit keeps its condition out of both the status register and the pin.
// - A set mask bit lets its condition reach the status register but not the pin.
// - The pin stays active while any triggering status bit is set and drops only once all are clear.
// - Status bit 0 is set by supply arrival, an enable control write or a power-up enable change.
// - Status bit 1 is set when the boost over-voltage detector reports its threshold reached.
// - After one bit is cleared the pin stays active if another bit is or becomes set.
// - Power-up enable drops when audio input stops and rises with a new power event when it returns.
// - An over-voltage event raised by enabling the output stays latched until the host clears it.
module amp_fault_irq_controller (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        supplyGood,
   input  wire logic        boostOverVoltage,
   input  wire logic        audioDataPresent,
   input  wire logic        enableControlWrite,
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   input  wire logic [7:0]  regAddr,
   input  wire logic [15:0] regWrData,
   output logic      [15:0] regRdData,
   output logic             regRdValid,
   output logic             irqPin,
   output logic             irqPinOe,
   output logic             powerUpEnable
);

   localparam int NC = `AFI_NUM_COND;

   amp_fault_irq_pkg::reg_word_t ctrl_r;
   amp_fault_irq_pkg::reg_word_t ctrl_nxt;
   amp_fault_irq_pkg::reg_word_t ioCfg_r;
   amp_fault_irq_pkg::reg_word_t ioCfg_nxt;
   amp_fault_irq_pkg::reg_word_t rdData_r;
   amp_fault_irq_pkg::reg_word_t rdData_nxt;
   amp_fault_irq_pkg::reg_sel_t  sel;
   logic [NC-1:0] status_r;
   logic [NC-1:0] status_nxt;
   logic [NC-1:0] condEvent;
   logic [NC-1:0] clrBits;
   logic [NC-1:0] disableBits;
   logic [NC-1:0] maskBits;
   logic          rdValid_r;
   logic          rdValid_nxt;
   logic          irqPin_r;
   logic          irqPin_nxt;
   logic          irqOe_r;
   logic          irqOe_nxt;
   logic          pue_r;
   logic          pue_nxt;
   logic          pending;
   logic [2:0]    syncLevel;
   logic [2:0]    syncRise;
   logic [2:0]    syncFall;

   // Pins from the supply monitor, boost detector and clock detector are asynchronous.
   cond_sync_edge #(
      .WIDTH (3)
   ) u_sync (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .asyncIn   ({audioDataPresent, boostOverVoltage, supplyGood}),
      .syncLevel (syncLevel),
      .syncRise  (syncRise),
      .syncFall  (syncFall)
   );

   // Address decode; unmapped addresses select nothing and read as zero.
   always_comb begin
      unique case (regAddr)
         `AFI_ADDR_INT_ENABLE_MASK:  sel = amp_fault_irq_pkg::SEL_ENABLE_MASK;
         `AFI_ADDR_INT_STATUS_CLEAR: sel = amp_fault_irq_pkg::SEL_STATUS_CLEAR;
         `AFI_ADDR_PIN_IO_CONFIG:    sel = amp_fault_irq_pkg::SEL_IO_CONFIG;
         default:                    sel = amp_fault_irq_pkg::SEL_NONE;
      endcase
   end

   assign disableBits = ctrl_r[`AFI_DISABLE_LSB +: NC];
   assign maskBits    = ctrl_r[`AFI_MASK_LSB +: NC];

   // Power-up enable simply follows the synchronised audio presence.
   assign pue_nxt = syncLevel[2];

   // Condition events: any power-up enable edge counts, so a returning input re-arms bit 0.
   always_comb begin
      condEvent                     = '0;
      condEvent[`AFI_COND_POWER]    = syncRise[0] | enableControlWrite
                                      | syncRise[2] | syncFall[2];
      condEvent[`AFI_COND_BOOST_OV] = syncRise[1];
   end

   // Status update: disabled conditions never latch, and a new event beats a same-cycle clear.
   always_comb begin
      clrBits = '0;
      if (regWrEn && sel == amp_fault_irq_pkg::SEL_STATUS_CLEAR) begin
         clrBits = regWrData[NC-1:0];
      end
      status_nxt = (status_r & ~clrBits) | (condEvent & ~disableBits);
   end

   // Control register writes.
   always_comb begin
      ctrl_nxt  = ctrl_r;
      ioCfg_nxt = ioCfg_r;
      if (regWrEn && sel == amp_fault_irq_pkg::SEL_ENABLE_MASK) begin
         ctrl_nxt = regWrData;
      end
      if (regWrEn && sel == amp_fault_irq_pkg::SEL_IO_CONFIG) begin
         ioCfg_nxt = regWrData;
      end
   end

   // Pin is computed from next values so it moves in the same edge as the status bits.
   always_comb begin
      pending    = |(status_nxt & ~ctrl_nxt[`AFI_MASK_LSB +: NC]);
      irqPin_nxt = ioCfg_nxt[`AFI_IO_ACTIVE_HIGH_BIT] ? pending : ~pending;
      irqOe_nxt  = ioCfg_nxt[`AFI_IO_OUT_ENABLE_BIT];
   end

   // Read path answers one cycle after the strobe; reads have no side effects.
   always_comb begin
      rdValid_nxt = regRdEn;
      rdData_nxt  = 16'h0000;
      if (regRdEn) begin
         unique case (sel)
            amp_fault_irq_pkg::SEL_ENABLE_MASK:  rdData_nxt = ctrl_r;
            amp_fault_irq_pkg::SEL_STATUS_CLEAR: rdData_nxt = {{(16-NC){1'b0}}, status_r};
            amp_fault_irq_pkg::SEL_IO_CONFIG:    rdData_nxt = ioCfg_r;
            amp_fault_irq_pkg::SEL_NONE:         rdData_nxt = 16'h0000;
         endcase
      end
   end

   // All state registers; reset leaves the pin undriven at its inactive-high level.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_r    <= `AFI_RST_INT_ENABLE_MASK;
         ioCfg_r   <= `AFI_RST_PIN_IO_CONFIG;
         status_r  <= '0;
         rdData_r  <= 16'h0000;
         rdValid_r <= 1'h0;
         irqPin_r  <= 1'h1;
         irqOe_r   <= 1'h0;
         pue_r     <= 1'h0;
      end else begin
         ctrl_r    <= ctrl_nxt;
         ioCfg_r   <= ioCfg_nxt;
         status_r  <= status_nxt;
         rdData_r  <= rdData_nxt;
         rdValid_r <= rdValid_nxt;
         irqPin_r  <= irqPin_nxt;
         irqOe_r   <= irqOe_nxt;
         pue_r     <= pue_nxt;
      end
   end

   assign regRdData     = rdData_r;
   assign regRdValid    = rdValid_r;
   assign irqPin        = irqPin_r;
   assign irqPinOe      = irqOe_r;
   assign powerUpEnable = pue_r;

   // Checks on the interrupt behaviour.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   logic irqActive;
   assign irqActive = irqPin_r == ioCfg_r[`AFI_IO_ACTIVE_HIGH_BIT];

   AST_IRQ_ON_PENDING: assert property (
      (|(status_r & ~maskBits)) |-> irqActive)
      else $error("IRQ pin inactive although an unmasked status bit is set.");

   AST_OE_FOLLOWS_CFG: assert property (
      regWrEn && sel == amp_fault_irq_pkg::SEL_IO_CONFIG |=>
      irqPinOe == $past(regWrData[`AFI_IO_OUT_ENABLE_BIT]))
      else $error("IRQ output enable does not follow the written configuration.");

   AST_W1C_CLEARS: assert property (
      regWrEn && sel == amp_fault_irq_pkg::SEL_STATUS_CLEAR && regWrData[1] && !syncRise[1]
      |=> !status_r[1])
      else $error("Writing one did not clear the status bit.");

   AST_W0_KEEPS: assert property (
      regWrEn && sel == amp_fault_irq_pkg::SEL_STATUS_CLEAR && !regWrData[0] && status_r[0]
      |=> status_r[0])
      else $error("Writing zero changed a status bit.");

   AST_DISABLE_BLOCKS: assert property (
      !status_r[1] && disableBits[1] |=> !status_r[1])
      else $error("A disabled condition set its status bit.");

   AST_MASK_HIDES: assert property (
      (status_r != '0) && ((status_r & ~maskBits) == '0) |-> !irqActive)
      else $error("A masked status bit drove the IRQ pin.");

   AST_IRQ_DROPS_WHEN_CLEAR: assert property (
      status_r == '0 |-> !irqActive)
      else $error("IRQ pin active with every status bit clear.");

   AST_POWER_EVENT: assert property (
      enableControlWrite && !disableBits[0] |=> status_r[0])
      else $error("Enable control write did not set the power status bit.");

   AST_OV_EVENT_SET_WINS: assert property (
      syncRise[1] && !disableBits[1] |=> status_r[1] ##1 status_r[1] || $past(regWrEn))
      else $error("Boost over-voltage event was lost.");

   AST_PUE_RETURN: assert property (
      $rose(syncLevel[2]) && !disableBits[0] |=> powerUpEnable && status_r[0])
      else $error("Audio return did not raise power-up enable and the power bit.");

   COV_OV_LATCH: cover property (syncRise[1] ##1 status_r[1] ##[1:20] irqActive);
   COV_TWO_PENDING: cover property (status_r == 2'h3 ##[1:20] status_r == 2'h2);
   COV_AUDIO_DROP: cover property ($fell(powerUpEnable) ##[1:50] $rose(powerUpEnable));

endmodule : amp_fault_irq_controller
`default_nettype wire

// *** testbench/host_ctrl_model.sv ***
// Host controller model: register port master and interrupt service routine.
`timescale 1ns/1ns
`default_nettype none
`include "amp_fault_irq_params.svh"

module host_ctrl_model #(
   parameter bit ACTIVE_HIGH = 1'b1
) (
   input  wire logic        clk,
   input  wire logic        irqPin,
   input  wire logic [15:0] regRdData,
   input  wire logic        regRdValid,
   output logic             regWrEn,
   output logic             regRdEn,
   output logic      [7:0]  regAddr,
   output logic      [15:0] regWrData
);
   // Strobes idle low from time zero.
   initial begin
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = 8'h00;
      regWrData = 16'h0000;
   end

   // One write; data is inverted after release so a stale word never looks valid.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWrEn <= 1'b0;
      regWrData <= ~d;
   endtask : wr

   // One read; the answer is taken at the edge that ends its single valid cycle.
   task automatic rd(input logic [7:0] a, output logic [16:0] q);
      @(posedge clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRdEn <= 1'b0;
      @(posedge clk);
      q = {regRdValid, regRdData};
   endtask : rd

   // Service loop, bounded so a stuck pin cannot hang the host.
   task automatic isr(output int passes);
      logic [16:0] q;
      passes = 0;
      while (irqPin === ACTIVE_HIGH && passes < 8) begin
         rd(`AFI_ADDR_INT_STATUS_CLEAR, q);
         wr(`AFI_ADDR_INT_STATUS_CLEAR, q[15:0] & (~q[15:0] + 16'h0001));
         repeat (2) @(posedge clk);
         passes++;
      end
   endtask : isr
endmodule : host_ctrl_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench of the amplifier fault interrupt controller.
`timescale 1ns/1ns
`default_nettype none
`include "amp_fault_irq_params.svh"

module tb_top;
   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] io;
      logic [1:0]  src;
      logic [15:0] st;
      logic        act;
   } row_t;
   localparam logic [7:0] CTRL = `AFI_ADDR_INT_ENABLE_MASK;
   localparam logic [7:0] STAT = `AFI_ADDR_INT_STATUS_CLEAR;
   localparam logic [7:0] IOC  = `AFI_ADDR_PIN_IO_CONFIG;
   logic clk, sysRst, supplyGood, boostOverVoltage, audioDataPresent, enableControlWrite;
   logic regWrEn, regRdEn, regRdValid, irqPin, irqPinOe, powerUpEnable;
   logic [7:0]  regAddr;
   logic [15:0] regWrData, regRdData;
   logic [16:0] q;
   int errors = 0, total_checks = 0, cycles = 0, n;
   // Source codes: 0 supply, 1 over-voltage, 2 enable write, 3 audio toggle.
   row_t rows [8] = '{'{16'h0000, 16'h8800, 2'h0, 16'h0001, 1'b1},
                      '{16'h0000, 16'h0800, 2'h1, 16'h0002, 1'b1},
                      '{16'h0001, 16'h8800, 2'h2, 16'h0001, 1'b0},
                      '{16'h0200, 16'h8800, 2'h1, 16'h0000, 1'b0},
                      '{16'h0100, 16'h8800, 2'h0, 16'h0000, 1'b0},
                      '{16'h0002, 16'h8800, 2'h1, 16'h0002, 1'b0},
                      '{16'h0000, 16'h8800, 2'h3, 16'h0001, 1'b1},
                      '{16'h0000, 16'h8800, 2'h3, 16'h0001, 1'b1}};

   amp_fault_irq_controller dut (.clk(clk), .sys_rst(sysRst), .supplyGood(supplyGood),
      .boostOverVoltage(boostOverVoltage), .audioDataPresent(audioDataPresent),
      .enableControlWrite(enableControlWrite), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .regRdValid(regRdValid), .irqPin(irqPin), .irqPinOe(irqPinOe),
      .powerUpEnable(powerUpEnable));

   host_ctrl_model #(.ACTIVE_HIGH(1'b1)) host (.clk(clk), .irqPin(irqPin),
      .regRdData(regRdData), .regRdValid(regRdValid), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regAddr(regAddr), .regWrData(regWrData));

   // Free-running 100 ns clock.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // A hang is cut short well beyond the few hundred cycles the run needs.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         results();
      end
   end

   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Async sources are held several cycles so the synchroniser cannot miss them.
   task automatic fire(input logic [1:0] s);
      @(posedge clk);
      case (s)
         2'h0: supplyGood <= 1'b1;
         2'h1: boostOverVoltage <= 1'b1;
         2'h2: enableControlWrite <= 1'b1;
         default: audioDataPresent <= ~audioDataPresent;
      endcase
      @(posedge clk);
      enableControlWrite <= 1'b0;
      repeat (4) @(posedge clk);
      supplyGood <= 1'b0;
      boostOverVoltage <= 1'b0;
   endtask : fire

   task automatic idle_check(input logic hi);
      host.rd(CTRL, q);
      check(q, 17'h10000);
      host.rd(STAT, q);
      check(q, 17'h10000);
      check({15'h0000, irqPinOe, irqPin}, {16'h0000, ~hi});
   endtask : idle_check

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results

   // Table first, then the hand-written corner cases.
   initial begin
      {supplyGood, boostOverVoltage, audioDataPresent, enableControlWrite} = 4'h0;
      sysRst = 1'b1;
      repeat (16) @(posedge clk);
      sysRst <= 1'b0;
      idle_check(1'b0);
      $display("reset values done");
      for (int i = 0; i < 8; i++) begin
         host.wr(CTRL, rows[i].ctrl);
         host.wr(IOC, rows[i].io);
         fire(rows[i].src);
         host.rd(STAT, q);
         check(q, {1'b1, rows[i].st});
         check({15'h0000, irqPinOe, irqPin}, {15'h0000, rows[i].io[11], rows[i].io[15] ^ ~rows[i].act});
         check({16'h0000, powerUpEnable}, {16'h0000, audioDataPresent});
         host.wr(STAT, rows[i].st);
         // The pin moves on the clearing edge itself, so look half a cycle later.
         @(negedge clk);
         check({16'h0000, irqPin}, {16'h0000, ~rows[i].io[15]});
         $display("row %0d done", i);
      end
      // Two pending conditions; a zero write keeps both, then they clear one at a time.
      fire(2'h2);
      fire(2'h1);
      host.wr(STAT, 16'h0000);
      host.rd(STAT, q);
      check(q, 17'h10003);
      check({16'h0000, irqPin}, 17'h00001);
      host.wr(STAT, 16'h0001);
      host.rd(STAT, q);
      check(q, 17'h10002);
      check({16'h0000, irqPin}, 17'h00001);
      host.wr(STAT, 16'h0002);
      @(negedge clk);
      check({16'h0000, irqPin}, 17'h00000);
      $display("sequential clear done");
      // A new event landing on the clearing edge survives it.
      fire(2'h2);
      fork
         host.wr(STAT, 16'h0001);
         begin
            @(posedge clk);
            enableControlWrite <= 1'b1;
            @(posedge clk);
            enableControlWrite <= 1'b0;
         end
      join
      host.rd(STAT, q);
      check(q, 17'h10001);
      host.wr(STAT, 16'h0001);
      host.rd(8'h07, q);
      check(q, 17'h10000);
      $display("set wins and unmapped done");
      fire(2'h0);
      fire(2'h1);
      host.isr(n);
      host.rd(STAT, q);
      check(q, 17'h10000);
      check({16'h0000, irqPin}, 17'h00000);
      check(17'(n), 17'h00002);
      $display("service routine done");
      // Masked and disabled, so the over-voltage bit stays clear and the reset must clear the control word.
      host.wr(CTRL, 16'h0F03);
      fire(2'h1);
      @(posedge clk);
      sysRst <= 1'b1;
      repeat (2) @(posedge clk);
      sysRst <= 1'b0;
      idle_check(1'b0);
      $display("mid-run reset done");
      results();
   end
endmodule : tb_top
`default_nettype wire
